// ==== page_regs_defines.svh ====
`ifndef PAGE_REGS_DEFINES_SVH
`define PAGE_REGS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_DIGITAL_PAGE_SELECT 8'h12
`define ADDR_ANALOG_PAGE_SELECT 8'h13
`define ADDR_TRIM_LOAD_RATE 8'h64
`define ADDR_USER_PATTERN_ONE_LOW 8'h8D
`define ADDR_USER_PATTERN_ONE_HIGH 8'h8E
`define ADDR_USER_PATTERN_TWO_LOW 8'h8F
`define ADDR_USER_PATTERN_TWO_HIGH 8'h90
`define ADDR_PATTERN_CONTROL 8'h91

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_DIGITAL_TOP 0
`define BIT_CHANNEL_A 1
`define BIT_CHANNEL_B 2
`define BIT_CHANNEL_C 3
`define BIT_CHANNEL_D 4
`define BIT_SERIALIZER_AB 5
`define BIT_SERIALIZER_CD 6
`define BIT_ANALOG 0
`define BIT_TRIM_RATE 1
`define LSB_PATTERN_KIND 4

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define MASK_DIGITAL_PAGE_SELECT 8'h7F
`define MASK_ANALOG_PAGE_SELECT 8'h01
`define MASK_TRIM_LOAD_RATE 8'h02
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

// ----------------------------------------------------------------
// Pattern kinds and fixed words
// ----------------------------------------------------------------
`define KIND_ALL_ZEROS 4'h1
`define KIND_ALL_ONES 4'h2
`define KIND_TOGGLE 4'h3
`define KIND_RAMP 4'h4
`define KIND_USER_ONE 4'h6
`define KIND_USER_ALTERNATE 4'h7
`define KIND_DESKEW 4'h8
`define WORD_ALL_ONES 16'hFFFF
`define WORD_TOGGLE_EVEN 16'h5555
`define WORD_TOGGLE_ODD 16'hAAAA
`define WORD_DESKEW 16'hAAAA
`define RAMP_STEP 16'h0001

`endif

// ==== page_regs_pkg.sv ====
package page_regs_pkg;

    // Register access carried by the serial interface core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Page enables as stored in the global page select register
    typedef struct packed {
        logic serializer_cd_page_enable;
        logic serializer_ab_page_enable;
        logic channel_d_page_enable;
        logic channel_c_page_enable;
        logic channel_b_page_enable;
        logic channel_a_page_enable;
        logic digital_top_page_enable;
    } page_enables_t;

    // Pages outside this block: analog, serializer CD/AB, channel D..A
    typedef logic [6:0] ext_pages_t;

    typedef logic [3:0] pattern_kind_t;

    typedef logic [3:0][15:0] chan_data_t;

endpackage : page_regs_pkg

// ==== pattern_source.sv ====
`timescale 1ns/10ps
`include "page_regs_defines.svh"

module pattern_source
    import page_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire pattern_kind_t pattern_kind_sel,
    input wire logic pattern_on,
    input wire logic [15:0] user_pattern_one,
    input wire logic [15:0] user_pattern_two,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out
);

    logic [15:0] data_out_nxt;
    logic [15:0] ramp_r;
    logic [15:0] ramp_nxt;
    logic phase_r;
    logic phase_nxt;

    // ----------------------------------------------------------------
    // Pattern selection
    // ----------------------------------------------------------------
    always_comb begin
        ramp_nxt = ramp_r + `RAMP_STEP;
        phase_nxt = ~phase_r;
        data_out_nxt = data_in;
        if (pattern_on) begin
            case (pattern_kind_sel)
                `KIND_ALL_ZEROS: data_out_nxt = `RESET_WORD;
                `KIND_ALL_ONES: data_out_nxt = `WORD_ALL_ONES;
                `KIND_TOGGLE: data_out_nxt = phase_r ? `WORD_TOGGLE_ODD : `WORD_TOGGLE_EVEN;
                `KIND_RAMP: data_out_nxt = ramp_r;
                `KIND_USER_ONE: data_out_nxt = user_pattern_one;
                `KIND_USER_ALTERNATE: begin
                    data_out_nxt = phase_r ? user_pattern_two : user_pattern_one;
                end
                `KIND_DESKEW: data_out_nxt = `WORD_DESKEW;
                default: data_out_nxt = data_in;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= `RESET_WORD;
            ramp_r <= `RESET_WORD;
            phase_r <= 1'b0;
        end else begin
            data_out <= data_out_nxt;
            ramp_r <= ramp_nxt;
            phase_r <= phase_nxt;
        end
    end

endmodule : pattern_source

// ==== page_regs.sv ====
// Summary of operation
// - Global 0x12 bit 6 enables serializer CD register page.
// - Global 0x12 bit 5 enables serializer AB register page.
// - Global 0x12 bits 4..1 enable channel pages D, C, B, A.
// - Global 0x12 bit 0 enables the digital-top register page.
// - Global 0x13 bit 0 selects the analog register page.
// - Digital-top 0x64 bit 1 picks trim load rate: 0 slow, 1 fast.
// - User pattern one is 0x8E:0x8D, used in single and dual modes.
// - User pattern two is 0x90:0x8F, used only in dual mode.
// - All these registers clear to zero on reset.
// - Pattern kinds: zeros, ones, toggle, ramp, user one, alternate, deskew.
// - Per-channel enable swaps normal data for the test pattern.
`timescale 1ns/10ps
`include "page_regs_defines.svh"

module page_regs
    import page_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output reg_req_t ext_req,
    output ext_pages_t ext_page_sel,
    input wire logic [7:0] ext_rdata,
    output page_enables_t page_enables,
    output logic analog_page_enable,
    output logic trim_load_rate_sel,
    input wire chan_data_t chan_data_in,
    output chan_data_t chan_data_out
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] digital_page_select_r;
    logic [7:0] digital_page_select_nxt;
    logic [7:0] analog_page_select_r;
    logic [7:0] analog_page_select_nxt;
    logic [7:0] trim_load_rate_r;
    logic [7:0] trim_load_rate_nxt;
    logic [15:0] user_pattern_one_r;
    logic [15:0] user_pattern_one_nxt;
    logic [15:0] user_pattern_two_r;
    logic [15:0] user_pattern_two_nxt;
    pattern_kind_t pattern_kind_sel_r;
    pattern_kind_t pattern_kind_sel_nxt;
    logic [3:0] chan_pattern_on_r;
    logic [3:0] chan_pattern_on_nxt;

    logic is_global;
    logic digital_top_hit;
    logic digital_top_on;
    ext_pages_t ext_pages_on;

    // ----------------------------------------------------------------
    // Read pipeline state
    // ----------------------------------------------------------------
    logic [7:0] local_rdata_r;
    logic [7:0] local_rdata_nxt;
    logic rd_pending_r;
    logic rd_pending_nxt;
    logic ext_rd_pending_r;
    logic ext_rd_pending_nxt;
    logic [7:0] rdata_nxt;
    logic rdata_valid_nxt;
    reg_req_t ext_req_nxt;
    ext_pages_t ext_page_sel_nxt;
    page_enables_t page_enables_nxt;
    logic analog_page_enable_nxt;
    logic trim_load_rate_sel_nxt;

    // ----------------------------------------------------------------
    // Page decode
    // ----------------------------------------------------------------
    always_comb begin
        is_global = (req.addr == `ADDR_DIGITAL_PAGE_SELECT) ||
                    (req.addr == `ADDR_ANALOG_PAGE_SELECT);
        digital_top_on = digital_page_select_r[`BIT_DIGITAL_TOP];
        ext_pages_on = {analog_page_select_r[`BIT_ANALOG],
                        digital_page_select_r[`BIT_SERIALIZER_CD],
                        digital_page_select_r[`BIT_SERIALIZER_AB],
                        digital_page_select_r[`BIT_CHANNEL_D],
                        digital_page_select_r[`BIT_CHANNEL_C],
                        digital_page_select_r[`BIT_CHANNEL_B],
                        digital_page_select_r[`BIT_CHANNEL_A]};
        digital_top_hit = !is_global && digital_top_on;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        digital_page_select_nxt = digital_page_select_r;
        analog_page_select_nxt = analog_page_select_r;
        trim_load_rate_nxt = trim_load_rate_r;
        user_pattern_one_nxt = user_pattern_one_r;
        user_pattern_two_nxt = user_pattern_two_r;
        pattern_kind_sel_nxt = pattern_kind_sel_r;
        chan_pattern_on_nxt = chan_pattern_on_r;
        if (req.wr) begin
            // Reserved bits are dropped so the registers always hold them at zero
            if (req.addr == `ADDR_DIGITAL_PAGE_SELECT) begin
                digital_page_select_nxt = req.wdata & `MASK_DIGITAL_PAGE_SELECT;
            end else if (req.addr == `ADDR_ANALOG_PAGE_SELECT) begin
                analog_page_select_nxt = req.wdata & `MASK_ANALOG_PAGE_SELECT;
            end else if (digital_top_hit) begin
                if (req.addr == `ADDR_TRIM_LOAD_RATE) begin
                    trim_load_rate_nxt = req.wdata & `MASK_TRIM_LOAD_RATE;
                end else if (req.addr == `ADDR_USER_PATTERN_ONE_LOW) begin
                    user_pattern_one_nxt[7:0] = req.wdata;
                end else if (req.addr == `ADDR_USER_PATTERN_ONE_HIGH) begin
                    user_pattern_one_nxt[15:8] = req.wdata;
                end else if (req.addr == `ADDR_USER_PATTERN_TWO_LOW) begin
                    user_pattern_two_nxt[7:0] = req.wdata;
                end else if (req.addr == `ADDR_USER_PATTERN_TWO_HIGH) begin
                    user_pattern_two_nxt[15:8] = req.wdata;
                end else if (req.addr == `ADDR_PATTERN_CONTROL) begin
                    pattern_kind_sel_nxt = req.wdata[7:`LSB_PATTERN_KIND];
                    chan_pattern_on_nxt = req.wdata[3:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Local read data
    // ----------------------------------------------------------------
    always_comb begin
        local_rdata_nxt = `RESET_BYTE;
        if (req.addr == `ADDR_DIGITAL_PAGE_SELECT) begin
            local_rdata_nxt = digital_page_select_r;
        end else if (req.addr == `ADDR_ANALOG_PAGE_SELECT) begin
            local_rdata_nxt = analog_page_select_r;
        end else if (digital_top_hit) begin
            if (req.addr == `ADDR_TRIM_LOAD_RATE) begin
                local_rdata_nxt = trim_load_rate_r;
            end else if (req.addr == `ADDR_USER_PATTERN_ONE_LOW) begin
                local_rdata_nxt = user_pattern_one_r[7:0];
            end else if (req.addr == `ADDR_USER_PATTERN_ONE_HIGH) begin
                local_rdata_nxt = user_pattern_one_r[15:8];
            end else if (req.addr == `ADDR_USER_PATTERN_TWO_LOW) begin
                local_rdata_nxt = user_pattern_two_r[7:0];
            end else if (req.addr == `ADDR_USER_PATTERN_TWO_HIGH) begin
                local_rdata_nxt = user_pattern_two_r[15:8];
            end else if (req.addr == `ADDR_PATTERN_CONTROL) begin
                local_rdata_nxt = {pattern_kind_sel_r, chan_pattern_on_r};
            end
        end
    end

    // ----------------------------------------------------------------
    // Forwarding to outer pages and read merge
    // ----------------------------------------------------------------
    always_comb begin
        ext_req_nxt = req;
        ext_req_nxt.wr = req.wr && !is_global && (ext_pages_on != 7'h00);
        ext_req_nxt.rd = req.rd && !is_global && (ext_pages_on != 7'h00);
        ext_page_sel_nxt = is_global ? 7'h00 : ext_pages_on;
        rd_pending_nxt = req.rd;
        ext_rd_pending_nxt = ext_req_nxt.rd;
        rdata_valid_nxt = rd_pending_r;
        rdata_nxt = rdata;
        if (rd_pending_r) begin
            // Several selected pages answer together, so their data merge
            rdata_nxt = local_rdata_r | (ext_rd_pending_r ? ext_rdata : `RESET_BYTE);
        end
        page_enables_nxt = digital_page_select_nxt[6:0];
        analog_page_enable_nxt = analog_page_select_nxt[`BIT_ANALOG];
        trim_load_rate_sel_nxt = trim_load_rate_nxt[`BIT_TRIM_RATE];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            digital_page_select_r <= `RESET_BYTE;
            analog_page_select_r <= `RESET_BYTE;
            trim_load_rate_r <= `RESET_BYTE;
            user_pattern_one_r <= `RESET_WORD;
            user_pattern_two_r <= `RESET_WORD;
            pattern_kind_sel_r <= 4'h0;
            chan_pattern_on_r <= 4'h0;
        end else begin
            digital_page_select_r <= digital_page_select_nxt;
            analog_page_select_r <= analog_page_select_nxt;
            trim_load_rate_r <= trim_load_rate_nxt;
            user_pattern_one_r <= user_pattern_one_nxt;
            user_pattern_two_r <= user_pattern_two_nxt;
            pattern_kind_sel_r <= pattern_kind_sel_nxt;
            chan_pattern_on_r <= chan_pattern_on_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            local_rdata_r <= `RESET_BYTE;
            rd_pending_r <= 1'b0;
            ext_rd_pending_r <= 1'b0;
            rdata <= `RESET_BYTE;
            rdata_valid <= 1'b0;
            ext_req <= '0;
            ext_page_sel <= 7'h00;
            page_enables <= '0;
            analog_page_enable <= 1'b0;
            trim_load_rate_sel <= 1'b0;
        end else begin
            local_rdata_r <= local_rdata_nxt;
            rd_pending_r <= rd_pending_nxt;
            ext_rd_pending_r <= ext_rd_pending_nxt;
            rdata <= rdata_nxt;
            rdata_valid <= rdata_valid_nxt;
            ext_req <= ext_req_nxt;
            ext_page_sel <= ext_page_sel_nxt;
            page_enables <= page_enables_nxt;
            analog_page_enable <= analog_page_enable_nxt;
            trim_load_rate_sel <= trim_load_rate_sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Test pattern per channel
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        pattern_source u_pattern_source (
            .core_clk(core_clk),
            .resetn(resetn),
            .pattern_kind_sel(pattern_kind_sel_r),
            .pattern_on(chan_pattern_on_r[ch]),
            .user_pattern_one(user_pattern_one_r),
            .user_pattern_two(user_pattern_two_r),
            .data_in(chan_data_in[ch]),
            .data_out(chan_data_out[ch])
        );
    end

endmodule : page_regs

// ==== page_regs_props.sv ====
`timescale 1ns/10ps
module page_regs_props
    import page_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire reg_req_t ext_req,
    input wire ext_pages_t ext_page_sel,
    input wire logic [7:0] ext_rdata,
    input wire page_enables_t page_enables,
    input wire logic analog_page_enable,
    input wire logic trim_load_rate_sel,
    input wire chan_data_t chan_data_in,
    input wire chan_data_t chan_data_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic glob = (req.addr == 8'h12) || (req.addr == 8'h13);
    wire logic dtop = page_enables.digital_top_page_enable;
    chk_read_answer: assert property (req.rd |-> ##2 rdata_valid)
        else $error("read answer missing");
    chk_answer_cause: assert property (rdata_valid |-> $past(req.rd, 2))
        else $error("read answer without request");
    chk_page_write: assert property (req.wr && req.addr == 8'h12
        |=> page_enables == $past(req.wdata[6:0])) else $error("page select write wrong");
    chk_analog_write: assert property (req.wr && req.addr == 8'h13
        |=> analog_page_enable == $past(req.wdata[0])) else $error("analog select wrong");
    chk_trim_write: assert property (req.wr && req.addr == 8'h64 && dtop
        |=> trim_load_rate_sel == $past(req.wdata[1])) else $error("trim rate write wrong");
    chk_trim_locked: assert property (req.wr && req.addr == 8'h64 && !dtop
        |=> $stable(trim_load_rate_sel)) else $error("trim rate changed while page off");
    chk_global_kept: assert property ((req.rd || req.wr) && glob
        |=> !ext_req.rd && !ext_req.wr && ext_page_sel == 7'h00) else $error("global forwarded");
    chk_forward_sel: assert property (req.rd && !glob
        |=> ext_page_sel == $past({analog_page_enable, page_enables[6:1]})
        && ext_req.rd == (ext_page_sel != 7'h00) && ext_req.addr == $past(req.addr))
        else $error("outer page routing wrong");
    chk_reserved_zero: assert property (rdata_valid && $past(req.addr, 2) == 8'h13
        |-> rdata[7:1] == 7'h00) else $error("reserved bits not zero");
endmodule : page_regs_props
bind page_regs page_regs_props i_props (.core_clk(core_clk), .resetn(resetn), .req(req),
    .rdata(rdata), .rdata_valid(rdata_valid), .ext_req(ext_req), .ext_page_sel(ext_page_sel),
    .ext_rdata(ext_rdata), .page_enables(page_enables), .analog_page_enable(analog_page_enable),
    .trim_load_rate_sel(trim_load_rate_sel), .chan_data_in(chan_data_in),
    .chan_data_out(chan_data_out));

// ==== page_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, (e), (g)); end end
module page_regs_tb
    import page_regs_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req = '0;
    logic [7:0] ext_rdata = 8'h00;
    chan_data_t chan_data_in = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    logic [7:0] rdata;
    logic rdata_valid, analog_page_enable, trim_load_rate_sel;
    reg_req_t ext_req;
    ext_pages_t ext_page_sel;
    page_enables_t page_enables;
    chan_data_t chan_data_out;
    int errors = 0;
    int n_tests = 0;

    page_regs i_dut (.core_clk(core_clk), .resetn(resetn), .req(req), .rdata(rdata),
        .rdata_valid(rdata_valid), .ext_req(ext_req), .ext_page_sel(ext_page_sel),
        .ext_rdata(ext_rdata), .page_enables(page_enables),
        .analog_page_enable(analog_page_enable), .trim_load_rate_sel(trim_load_rate_sel),
        .chan_data_in(chan_data_in), .chan_data_out(chan_data_out));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge core_clk);
        req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge core_clk);
        req = '0;
        // Answer stands for one cycle, two edges after the request edge
        @(negedge core_clk);
        `CHK("read valid", 1'b1, rdata_valid)
        `CHK("read data", e, rdata)
    endtask : rd

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        #400000;
        errors++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] locs [5];
        logic [3:0] kinds [4];
        logic [15:0] outs [4];
        logic [15:0] alt [4];
        logic [15:0] p;
        locs = '{8'h64, 8'h8D, 8'h8E, 8'h8F, 8'h90};
        kinds = '{4'h1, 4'h2, 4'h6, 4'h8};
        outs = '{16'h0000, 16'hFFFF, 16'h1234, 16'hAAAA};
        alt = '{16'h1234, 16'h5678, 16'h5555, 16'hAAAA};
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h00);
        wr(8'h12, 8'h01);
        for (int i = 0; i < 5; i++) rd(locs[i], 8'h00);
        wr(8'h12, 8'hFF);
        `CHK("page enables", 7'h7F, page_enables)
        rd(8'h12, 8'h7F);
        wr(8'h13, 8'hFF);
        `CHK("analog enable", 1'b1, analog_page_enable)
        rd(8'h13, 8'h01);
        wr(8'h64, 8'hFF);
        `CHK("trim rate", 1'b1, trim_load_rate_sel)
        rd(8'h64, 8'h02);
        wr(8'h64, 8'h00);
        `CHK("trim rate", 1'b0, trim_load_rate_sel)
        wr(8'h12, 8'h02);
        wr(8'h64, 8'hFF);
        `CHK("trim locked", 1'b0, trim_load_rate_sel)
        rd(8'h64, 8'h00);
        ext_rdata = 8'h5A;
        rd(8'h20, 8'h5A);
        ext_rdata = 8'h00;
        wr(8'h13, 8'h00);
        wr(8'h12, 8'h01);
        wr(8'h8D, 8'h34);
        wr(8'h8E, 8'h12);
        wr(8'h8F, 8'h78);
        wr(8'h90, 8'h56);
        rd(8'h8E, 8'h12);
        rd(8'h90, 8'h56);
        for (int i = 0; i < 4; i++) begin
            wr(8'h91, {kinds[i], 4'h1});
            repeat (3) @(negedge core_clk);
            `CHK("chan a pattern", outs[i], chan_data_out[0])
            `CHK("chan b normal", 16'h2222, chan_data_out[1])
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'h91, (i == 0) ? 8'h7F : 8'h3F);
            repeat (3) @(negedge core_clk);
            p = chan_data_out[3];
            @(negedge core_clk);
            `CHK("alt member", 1'b1, p === alt[2 * i] || p === alt[2 * i + 1])
            `CHK("alt next", (p === alt[2 * i]) ? alt[2 * i + 1] : alt[2 * i], chan_data_out[3])
        end
        wr(8'h91, 8'h41);
        repeat (3) @(negedge core_clk);
        p = chan_data_out[0];
        @(negedge core_clk);
        `CHK("ramp step", p + 16'h0001, chan_data_out[0])
        wr(8'h91, 8'h01);
        repeat (3) @(negedge core_clk);
        `CHK("default kind", 16'h1111, chan_data_out[0])
        wr(8'h91, 8'h20);
        repeat (3) @(negedge core_clk);
        `CHK("chan a off", 16'h1111, chan_data_out[0])
        test_done();
    end
endmodule : page_regs_tb
